//--- shared/msdt_defs.vh
// constants for the module status and device type register block
`ifndef MSDT_DEFS_VH
`define MSDT_DEFS_VH
// register numbers
`define MSDT_REG_STATUS 8'h00
`define MSDT_REG_DEVTYPE 8'h01
`define MSDT_REG_EXT_PTR_HI 8'h09
`define MSDT_REG_EXT_PTR_LO 8'h0A
`define MSDT_REG_EXT_DATA 8'h0B
// status register fields
`define MSDT_PEND_MSB 15
`define MSDT_PEND_LSB 8
`define MSDT_RSVD_MSB 7
`define MSDT_RSVD_LSB 5
`define MSDT_READY_BIT 4
`define MSDT_ERR_MSB 3
`define MSDT_ERR_LSB 0
`define MSDT_RSVD_VAL 3'h0
`define MSDT_ERR_RESET 4'h0
// error codes
`define MSDT_ERR_OK 4'h0
`define MSDT_ERR_NOT_IMPL 4'h1
`define MSDT_ERR_READ_ONLY 4'h2
`define MSDT_ERR_VALUE_RANGE 4'h3
`define MSDT_ERR_PENDING 4'h4
`define MSDT_ERR_INIT 4'h5
`define MSDT_ERR_EXT_RANGE 4'h6
`define MSDT_ERR_EXT_RO 4'h7
`define MSDT_ERR_EXEC_FAIL 4'h8
`define MSDT_ERR_OUT_ENABLED 4'h9
`define MSDT_ERR_INVALID_CFG 4'hA
`define MSDT_ERR_VENDOR 4'hF
// response status field
`define MSDT_STAT_MSB 25
`define MSDT_STAT_LSB 24
`define MSDT_STAT_OK 2'h0
`define MSDT_STAT_EXEC_ERR 2'h1
`define MSDT_STAT_EXT_ACCESS 2'h2
// device type string
`define MSDT_STR_LEN 16'h0008
`define MSDT_STR_BASE 16'h0000
`endif

//--- logic/msdt_string_rom.v
// rom holding the device type string, two bytes per word
`timescale 1ns/1ps
module msdt_string_rom (
  // word index and data
  input wire [1:0] word_idx,
  output reg [15:0] word_data
);
  // string bytes are arbitrary neutral text, earlier byte high
  always @* begin
    case (word_idx)
      2'h0: word_data = 16'h4C41;
      2'h1: word_data = 16'h5345;
      2'h2: word_data = 16'h5220;
      2'h3: word_data = 16'h5800;
      default: word_data = 16'h0000;
    endcase
  end
endmodule

//--- logic/msdt_regs.v
// status and device type command interpreter with extended string access
`timescale 1ns/1ps
`include "msdt_defs.vh"
// How it works
// - status bits 7:5 always read zero
// - status bit 4 shows module_ready, one means output may be enabled
// - module_ready low in warm-up or invalid configuration, high when able
// - status bits 3:0 hold the error code of the last command other than a pointer read
// - status read returns stored code, then clears error field to zero
// - codes 0 ok, 1 not implemented, 2 read-only, 3 value range
// - codes 4 pending, 5 initializing, 9 output enabled ignored
// - codes 6 extended range, 7 extended read-only, 8 execution failure
// - code A invalid config, F vendor; B to E never reported
// - device type read returns length eight with extended-access status
// - device type read points extended pointer registers at the string
// - write to device type gives execution error, register unchanged
// - failed device type read: execution error, zero data, error set
// - read past string end: execution error, zero data, code six
// - response status sits in bits 25:24 of the response frame
// - status write accepted without error, data not stored
// - status bits 15:8 show pending flags, zero when none
module msdt_regs (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // command from host
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_reg,
  input wire [15:0] cmd_data,
  // module condition
  input wire warm_up,
  input wire invalid_cfg,
  input wire [7:0] pending_flags,
  input wire [3:0] fault_code,
  // response to host
  output reg rsp_valid,
  output reg [31:0] rsp_frame,
  output wire module_ready,
  output wire [15:0] ext_ptr
);

  // ********************************************************
  // state
  // ********************************************************
  reg [3:0] err_r;
  reg [3:0] err_nxt;
  reg [15:0] ptr_r;
  reg [15:0] ptr_nxt;
  reg [15:0] data_nxt;
  reg [1:0] stat_nxt;
  wire [15:0] rom_word;
  wire [15:0] status_word;
  wire [15:0] ptr_off;
  wire past_end;

  // maps a requested failure cause onto a legal device type error
  function [3:0] msdt_legal_fail;
    input [3:0] code;
    begin
      case (code)
        `MSDT_ERR_PENDING: msdt_legal_fail = `MSDT_ERR_PENDING;
        `MSDT_ERR_INIT: msdt_legal_fail = `MSDT_ERR_INIT;
        `MSDT_ERR_VENDOR: msdt_legal_fail = `MSDT_ERR_VENDOR;
        default: msdt_legal_fail = `MSDT_ERR_EXEC_FAIL;
      endcase
    end
  endfunction

  // ready only outside warm-up and with a valid configuration
  assign module_ready = ~warm_up & ~invalid_cfg;
  assign ext_ptr = ptr_r;

  // ********************************************************
  // status word
  // ********************************************************
  // reserved bits come one by one from the defined value
  localparam [2:0] RSVD_CONST = `MSDT_RSVD_VAL;
  wire [2:0] rsvd_bits;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_rsvd
      // each reserved bit is a constant, never a stored value
      assign rsvd_bits[gi] = RSVD_CONST[gi];
    end
  endgenerate

  // status word layout
  assign status_word = {pending_flags,
                        rsvd_bits,
                        module_ready,
                        err_r};

  // string walk
  assign ptr_off = ptr_r - `MSDT_STR_BASE;
  assign past_end = (ptr_off >= `MSDT_STR_LEN);
  msdt_string_rom u_rom (
    .word_idx(ptr_off[2:1]),
    .word_data(rom_word)
  );

  // ********************************************************
  // command decode
  // ********************************************************
  // error codes used: B to E never produced
  always @* begin
    err_nxt = err_r;
    ptr_nxt = ptr_r;
    data_nxt = 16'h0000;
    stat_nxt = `MSDT_STAT_OK;
    case (cmd_reg)
      `MSDT_REG_STATUS: begin
        // read returns old code, field then reflects this ok command
        if (!cmd_write) begin
          data_nxt = status_word;
        end else begin
          data_nxt = cmd_data;
        end
        err_nxt = `MSDT_ERR_OK;
      end
      `MSDT_REG_DEVTYPE: begin
        if (cmd_write) begin
          stat_nxt = `MSDT_STAT_EXEC_ERR;
          err_nxt = `MSDT_ERR_READ_ONLY;
        end else if (!module_ready) begin
          stat_nxt = `MSDT_STAT_EXEC_ERR;
          err_nxt = `MSDT_ERR_INIT;
        end else if (pending_flags != 8'h00) begin
          stat_nxt = `MSDT_STAT_EXEC_ERR;
          err_nxt = `MSDT_ERR_PENDING;
        end else if (fault_code != `MSDT_ERR_OK) begin
          stat_nxt = `MSDT_STAT_EXEC_ERR;
          err_nxt = msdt_legal_fail(fault_code);
        end else begin
          stat_nxt = `MSDT_STAT_EXT_ACCESS;
          data_nxt = `MSDT_STR_LEN;
          ptr_nxt = `MSDT_STR_BASE;
          err_nxt = `MSDT_ERR_OK;
        end
      end
      `MSDT_REG_EXT_DATA: begin
        if (cmd_write) begin
          stat_nxt = `MSDT_STAT_EXEC_ERR;
          err_nxt = `MSDT_ERR_EXT_RO;
        end else if (past_end) begin
          stat_nxt = `MSDT_STAT_EXEC_ERR;
          err_nxt = `MSDT_ERR_EXT_RANGE;
        end else begin
          data_nxt = rom_word;
          ptr_nxt = ptr_r + 16'h0002;
          err_nxt = `MSDT_ERR_OK;
        end
      end
      `MSDT_REG_EXT_PTR_HI,
      `MSDT_REG_EXT_PTR_LO: begin
        // pointer halves are readable; writes fail with the read-only error
        if (cmd_write) begin
          stat_nxt = `MSDT_STAT_EXEC_ERR;
          err_nxt = `MSDT_ERR_READ_ONLY;
        end else if (cmd_reg == `MSDT_REG_EXT_PTR_HI) begin
          data_nxt = 16'h0000;
        end else begin
          data_nxt = ptr_r;
        end
      end
      default: begin
        stat_nxt = `MSDT_STAT_EXEC_ERR;
        err_nxt = `MSDT_ERR_NOT_IMPL;
      end
    endcase
  end

  // ********************************************************
  // error field guard
  // ********************************************************
  // true for the codes kept for later use, never to be stored
  function msdt_code_reserved;
    input [3:0] code;
    begin
      case (code)
        4'hB: msdt_code_reserved = 1'b1;
        4'hC: msdt_code_reserved = 1'b1;
        4'hD: msdt_code_reserved = 1'b1;
        4'hE: msdt_code_reserved = 1'b1;
        default: msdt_code_reserved = 1'b0;
      endcase
    end
  endfunction

  // a reserved code would be a decode fault; store general failure
  wire [3:0] err_store;
  assign err_store = msdt_code_reserved(err_nxt) ? `MSDT_ERR_EXEC_FAIL
                                                 : err_nxt;

  // ********************************************************
  // response frame helper
  // ********************************************************
  // packs status, register echo and data into one frame
  function [31:0] msdt_frame;
    input [1:0] stat;
    input [7:0] reg_num;
    input [15:0] data;
    begin
      // upper bits are unused and always zero
      msdt_frame = {6'h00, stat, reg_num, data};
    end
  endfunction

  // ********************************************************
  // error field
  // ********************************************************
  // updated by every command except pointer reads, which leave the previous code
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_r <= `MSDT_ERR_RESET;
    end else if (cmd_valid) begin
      err_r <= err_store;
    end
  end

  // ********************************************************
  // extended pointer
  // ********************************************************
  // reset leaves the pointer past the end, so early data reads fail
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_r <= `MSDT_STR_LEN;
    end else if (cmd_valid) begin
      ptr_r <= ptr_nxt;
    end
  end

  // ********************************************************
  // response strobe
  // ********************************************************
  // one response per command, one cycle after it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= cmd_valid;
    end
  end

  // ********************************************************
  // response frame
  // ********************************************************
  // frame holds until the next command is answered
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_frame <= 32'h0000_0000;
    end else if (cmd_valid) begin
      rsp_frame <= msdt_frame(stat_nxt, cmd_reg, data_nxt);
    end
  end
endmodule

//--- testbench/msdt_regs_chk.sv
// assertions on the status and device type register block
`timescale 1ns/1ps
module msdt_regs_chk (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // command and module condition
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_reg,
  input wire [15:0] cmd_data,
  input wire warm_up,
  input wire invalid_cfg,
  input wire [7:0] pending_flags,
  input wire [3:0] fault_code,
  // response
  input wire rsp_valid,
  input wire [31:0] rsp_frame,
  input wire module_ready,
  input wire [15:0] ext_ptr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // read strobe and clean device type conditions
  wire rd = cmd_valid && !cmd_write;
  wire ok = module_ready && pending_flags == 8'h00 && fault_code == 4'h0;
  chk_stat_bits: assert property (
    rd && cmd_reg == 8'h00 |=> rsp_frame[7:5] == 3'h0
    && rsp_frame[4] == $past(module_ready)) else $error("status bits bad");
  chk_ready_src: assert property (
    module_ready == !(warm_up || invalid_cfg)) else $error("ready bad");
  chk_frame_form: assert property (
    1 |=> rsp_valid == $past(cmd_valid) && rsp_frame[31:26] == 6'h00
    && rsp_frame[25:24] != 2'h3) else $error("frame form bad");
  chk_len_read: assert property (
    rd && cmd_reg == 8'h01 && ok |=> ext_ptr == 16'h0000
    && rsp_frame[25:0] == 26'h2010008) else $error("length read bad");
  chk_type_write: assert property (
    cmd_valid && cmd_write && cmd_reg == 8'h01 |=>
    rsp_frame[25:0] == 26'h1010000) else $error("type write bad");
  chk_busy_fail: assert property (
    rd && cmd_reg == 8'h01 && pending_flags != 8'h00 |=>
    rsp_frame[25:0] == 26'h1010000) else $error("busy read bad");
  chk_ptr_step: assert property (
    rd && cmd_reg == 8'h0B && ext_ptr < 16'h0008 |=> rsp_frame[25:24] == 2'h0
    && ext_ptr == $past(ext_ptr) + 16'h0002) else $error("step bad");
  chk_past_end: assert property (
    rd && cmd_reg == 8'h0B && ext_ptr >= 16'h0008 |=>
    rsp_frame[25:0] == 26'h10B0000) else $error("past end bad");
  chk_stat_write: assert property (
    cmd_valid && cmd_write && cmd_reg == 8'h00 |=>
    rsp_frame[25:0] == {10'h000, $past(cmd_data)}) else $error("write bad");
endmodule
bind msdt_regs msdt_regs_chk chk (.clk(clk), .arst_n(arst_n),
  .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_reg(cmd_reg),
  .cmd_data(cmd_data), .warm_up(warm_up), .invalid_cfg(invalid_cfg),
  .pending_flags(pending_flags), .fault_code(fault_code),
  .rsp_valid(rsp_valid), .rsp_frame(rsp_frame),
  .module_ready(module_ready), .ext_ptr(ext_ptr));

//--- testbench/msdt_host.sv
// host model issuing one command at a time and taking its answer
`timescale 1ns/1ps
module msdt_host (
  // clock
  input wire clk,
  // command out
  output reg cmd_valid,
  output reg cmd_write,
  output reg [7:0] cmd_reg,
  output reg [15:0] cmd_data,
  // answer in
  input wire rsp_valid,
  input wire [31:0] rsp_frame
);
  reg [31:0] got = 32'h0;
  initial begin
    {cmd_valid, cmd_write, cmd_reg, cmd_data} = 26'h0;
  end
  // drive on a falling edge, answer taken in its only valid cycle
  task send(input reg w, input reg [7:0] r, input reg [15:0] d);
    begin
      @(negedge clk);
      {cmd_valid, cmd_write, cmd_reg, cmd_data} = {1'b1, w, r, d};
      @(negedge clk);
      {cmd_valid, cmd_write, cmd_reg, cmd_data} = {1'b0, ~w, ~r, ~d};
      got = rsp_valid ? rsp_frame : 32'hFFFFFFFF;
    end
  endtask
endmodule

//--- testbench/msdt_regs_test.sv
// self-checking bench for the status and device type register block
`timescale 1ns/1ps
module msdt_regs_test;
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg warm_up = 1'b0;
  reg invalid_cfg = 1'b0;
  reg [7:0] pending_flags = 8'h00;
  reg [3:0] fault_code = 4'h0;
  wire cmd_valid, cmd_write, rsp_valid, module_ready;
  wire [7:0] cmd_reg;
  wire [15:0] cmd_data, ext_ptr;
  wire [31:0] rsp_frame;
  integer n_mismatch = 0;
  integer n_tests = 0;
  integer err = 0;
  integer ptr = 8;
  integer i;
  reg [31:0] seed = 32'h8D06;
  reg [15:0] rom [0:3];
  always #20 clk = ~clk;
  msdt_regs uut (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_reg(cmd_reg), .cmd_data(cmd_data),
    .warm_up(warm_up), .invalid_cfg(invalid_cfg),
    .pending_flags(pending_flags), .fault_code(fault_code),
    .rsp_valid(rsp_valid), .rsp_frame(rsp_frame),
    .module_ready(module_ready), .ext_ptr(ext_ptr));
  msdt_host host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_reg(cmd_reg), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_frame(rsp_frame));
  // xorshift step for random data
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // frame compare
  task chk(input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("Error rsp_frame expected %h seen %h", e, g);
      end
    end
  endtask
  // pointer compare
  task chk_ptr(input [15:0] e, input [15:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("Error ext_ptr expected %h seen %h", e, g);
      end
    end
  endtask
  // reference model of one command, then the real one
  task run(input reg w, input reg [7:0] r, input reg [15:0] d);
    reg [1:0] st;
    reg [15:0] q;
    reg rdy;
    begin
      rdy = !(warm_up || invalid_cfg);
      st = 2'h1;
      q = 16'h0000;
      if (r == 8'h00) begin
        st = 2'h0;
        q = w ? d : {pending_flags, 3'h0, rdy, err[3:0]};
        err = 0;
      end else if (r == 8'h01 && w) err = 2;
      else if (r == 8'h01 && !rdy) err = 5;
      else if (r == 8'h01 && pending_flags != 8'h00) err = 4;
      else if (r == 8'h01 && fault_code != 4'h0)
        err = (fault_code > 3 && fault_code < 6 || &fault_code) ? fault_code : 8;
      else if (r == 8'h01) begin
        {st, q, ptr, err} = {2'h2, 16'h0008, 32'd0, 32'd0};
      end else if (r == 8'h0B && ptr < 8) begin
        {st, q, err} = {2'h0, rom[ptr / 2], 32'd0};
        ptr = ptr + 2;
      end else if (r == 8'h0B) err = 6;
      else err = 1;
      host.send(w, r, d);
      chk({6'h00, st, r, q}, host.got);
      chk_ptr(ptr[15:0], ext_ptr);
    end
  endtask
  task final_report;
    begin
      if (n_mismatch == 0 && n_tests > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // watchdog
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  // scenarios
  initial begin
    {rom[0], rom[1], rom[2], rom[3]} = 64'h4C41534552205800;
    repeat (16) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    run(1'b0, 8'h0B, 16'h0);
    run(1'b0, 8'h00, 16'h0);
    run(1'b0, 8'h00, 16'h0);
    run(1'b0, 8'h01, 16'h0);
    for (i = 0; i < 5; i = i + 1) run(1'b0, 8'h0B, 16'h0);
    run(1'b0, 8'h00, 16'h0);
    run(1'b1, 8'h01, 16'h1234);
    run(1'b0, 8'h00, 16'h0);
    seed = xs(seed);
    run(1'b1, 8'h00, seed[15:0]);
    run(1'b0, 8'h20, 16'h0);
    run(1'b0, 8'h00, 16'h0);
    for (i = 1; i < 16; i = i + 1) begin
      fault_code = i;
      run(1'b0, 8'h01, 16'h0);
      run(1'b0, 8'h00, 16'h0);
    end
    fault_code = 4'h0;
    seed = xs(seed);
    pending_flags = seed[7:0] | 8'h01;
    run(1'b0, 8'h01, 16'h0);
    run(1'b0, 8'h00, 16'h0);
    pending_flags = 8'h00;
    for (i = 1; i < 4; i = i + 1) begin
      {warm_up, invalid_cfg} = i;
      run(1'b0, 8'h00, 16'h0);
      run(1'b0, 8'h01, 16'h0);
      run(1'b0, 8'h00, 16'h0);
    end
    final_report;
  end
endmodule
